// [hdl/sbp_sequential_port.sv]
`timescale 1ns/1ps
// Summary of operation
// - Sixteen-bit two-way sequential data bus.
// - Data and controls sampled on rising clock.
// - Count enable low advances pointer by one.
// - Increment ignores random-port chip enable.
// - Port enable sampled high disables, tristates.
// - Disabled port leaves array contents unchanged.
// - Write low with enable low starts write.
// - Read high, enables low starts read.
// - Write ends when write or enable high.
// - Pointer-load low captures low thirteen bits.
// - One cycle latency before pointer load.
// - Next cycle pointer takes captured value.
// - Start load copies start register into pointer.
// - End flag low when a count increment hits end.
// - Flags cleared by reset or control zero.
// - Two independent end compares and flags.
// - Output enable acts without the clock.
// - Reset clears start registers, pointer; end registers to 1FFF, control to 0003, flags high.
// - Reset acts asynchronously.
// - Array is 8192 words; pointers thirteen bits.
module sbp_sequential_port #(
    parameter int ADDR_W = sbp_pkg::ADDR_W,
    parameter int DATA_W = sbp_pkg::DATA_W,
    parameter int DEPTH = sbp_pkg::DEPTH
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [DATA_W-1:0] seqDataIn,
    output logic [DATA_W-1:0] seqDataOut,
    output logic seqDataOe_n,
    input wire logic seq_port_enable_n,
    input wire logic pointer_count_en_n,
    input wire logic seq_read_write,
    input wire logic pointer_load_n,
    input wire logic start_load_one_n,
    input wire logic start_load_two_n,
    input wire logic seq_output_enable_n,
    output logic end_flag_one_n,
    output logic end_flag_two_n,
    input wire logic regSelect_n,
    input wire logic regWrite,
    input wire logic [2:0] regAddr,
    input wire logic [ADDR_W-1:0] regDataIn,
    output logic [ADDR_W-1:0] regDataOut,
    input wire logic randEnable_n,
    input wire logic randWrite,
    input wire logic [ADDR_W-1:0] randAddr,
    input wire logic [DATA_W-1:0] randDataIn,
    output logic [DATA_W-1:0] randDataOut
);

    // ==========================================================
    // Input synchronisers for the data bus.
    logic [DATA_W-1:0] dataMeta;
    logic [DATA_W-1:0] dataSync;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dataMeta <= 16'h0000;
            dataSync <= 16'h0000;
        end else begin
            dataMeta <= seqDataIn;
            dataSync <= dataMeta;
        end
    end

    // ==========================================================
    // Input synchronisers for the port controls.
    logic [5:0] ctlMeta;
    logic [5:0] ctlSync;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctlMeta <= 6'h3F;
            ctlSync <= 6'h3F;
        end else begin
            ctlMeta <= {seq_port_enable_n, pointer_count_en_n, seq_read_write,
                        pointer_load_n, start_load_one_n, start_load_two_n};
            ctlSync <= ctlMeta;
        end
    end

    // ==========================================================
    // Input synchroniser for the output enable.
    logic soeMeta;
    logic soeSync;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            soeMeta <= 1'b1;
            soeSync <= 1'b1;
        end else begin
            soeMeta <= seq_output_enable_n;
            soeSync <= soeMeta;
        end
    end

    // ==========================================================
    // Input synchroniser for the register select.
    logic regSelMeta;
    logic regSelSync;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            regSelMeta <= 1'b1;
            regSelSync <= 1'b1;
        end else begin
            regSelMeta <= regSelect_n;
            regSelSync <= regSelMeta;
        end
    end

    // ==========================================================
    // Synchronised control levels.
    logic portEn_n;
    logic countEn_n;
    logic readWrite;
    logic ptrLoad_n;
    logic startOne_n;
    logic startTwo_n;
    assign portEn_n = ctlSync[5];
    assign countEn_n = ctlSync[4];
    assign readWrite = ctlSync[3];
    assign ptrLoad_n = ctlSync[2];
    assign startOne_n = ctlSync[1];
    assign startTwo_n = ctlSync[0];

    // ==========================================================
    // Array.
    logic [DATA_W-1:0] memArray [DEPTH];
    logic [ADDR_W-1:0] ptr_reg;
    logic portActive_reg;
    logic writeCycle_reg;
    logic [DATA_W-1:0] readData_reg;
    always_ff @(posedge clk) begin
        if (!portEn_n && !readWrite) begin
            memArray[ptr_reg] <= dataSync;
        end else if (!randEnable_n && randWrite) begin
            memArray[randAddr] <= randDataIn;
        end
    end

    // ==========================================================
    // Sequential read path.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            readData_reg <= 16'h0000;
        end else if (!portEn_n && readWrite && !soeSync) begin
            readData_reg <= memArray[ptr_reg];
        end
    end

    // ==========================================================
    // Random read path.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            randDataOut <= 16'h0000;
        end else begin
            randDataOut <= memArray[randAddr];
        end
    end

    // ==========================================================
    // Port power state.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            portActive_reg <= 1'b0;
        end else begin
            portActive_reg <= !portEn_n;
        end
    end

    // ==========================================================
    // Write cycle tracking.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            writeCycle_reg <= 1'b0;
        end else begin
            writeCycle_reg <= !portEn_n && !readWrite;
        end
    end

    // ==========================================================
    // Data bus drive; output enable is combinational.
    assign seqDataOut = readData_reg;
    assign seqDataOe_n = seq_output_enable_n || !portActive_reg || writeCycle_reg;

    // ==========================================================
    // Command registers.
    logic [ADDR_W-1:0] startOne_reg;
    logic [ADDR_W-1:0] startTwo_reg;
    logic [ADDR_W-1:0] endOne_reg;
    logic [ADDR_W-1:0] endTwo_reg;
    logic [15:0] control_reg;

    // ==========================================================
    // Register write strobe; writes wait while the random port is enabled.
    logic regWrStrobe;
    assign regWrStrobe = !regSelSync && regWrite && randEnable_n;

    // ==========================================================
    // Start register one.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            startOne_reg <= 13'h0000;
        end else if (regWrStrobe && regAddr == sbp_pkg::REG_START_ONE) begin
            startOne_reg <= regDataIn;
        end
    end

    // ==========================================================
    // Start register two.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            startTwo_reg <= 13'h0000;
        end else if (regWrStrobe && regAddr == sbp_pkg::REG_START_TWO) begin
            startTwo_reg <= regDataIn;
        end
    end

    // ==========================================================
    // End register one.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            endOne_reg <= 13'h1FFF;
        end else if (regWrStrobe && regAddr == sbp_pkg::REG_END_ONE) begin
            endOne_reg <= regDataIn;
        end
    end

    // ==========================================================
    // End register two.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            endTwo_reg <= 13'h1FFF;
        end else if (regWrStrobe && regAddr == sbp_pkg::REG_END_TWO) begin
            endTwo_reg <= regDataIn;
        end
    end

    // ==========================================================
    // Buffer control register.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            control_reg <= sbp_pkg::CTL_RESET;
        end else if (regWrStrobe && regAddr == sbp_pkg::REG_BUFFER_CONTROL) begin
            control_reg <= {3'h0, regDataIn};
        end
    end

    // ==========================================================
    // Register read-back.
    always_comb begin
        unique case (regAddr)
            sbp_pkg::REG_START_ONE: regDataOut = startOne_reg;
            sbp_pkg::REG_START_TWO: regDataOut = startTwo_reg;
            sbp_pkg::REG_END_ONE: regDataOut = endOne_reg;
            sbp_pkg::REG_END_TWO: regDataOut = endTwo_reg;
            sbp_pkg::REG_FLAGS: regDataOut = {11'h000, !end_flag_two_n, !end_flag_one_n};
            sbp_pkg::REG_BUFFER_CONTROL: regDataOut = control_reg[12:0];
            default: regDataOut = 13'h0000;
        endcase
    end
    logic ctlWrite;
    assign ctlWrite = regWrStrobe && regAddr == sbp_pkg::REG_BUFFER_CONTROL;

    // ==========================================================
    // Address pointer.
    logic [ADDR_W-1:0] loadData_reg;
    logic loadPending_reg;
    logic [ADDR_W-1:0] ptr_next;
    logic ptrAdvance;
    assign ptrAdvance = !countEn_n && !loadPending_reg && startOne_n && startTwo_n;
    assign ptr_next = ptr_reg + 13'h0001;

    // ==========================================================
    // Pointer-load capture.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            loadData_reg <= sbp_pkg::PTR_RESET;
        end else if (!ptrLoad_n) begin
            loadData_reg <= dataSync[ADDR_W-1:0];
        end
    end

    // ==========================================================
    // Pointer-load pending.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            loadPending_reg <= 1'b0;
        end else begin
            loadPending_reg <= !ptrLoad_n;
        end
    end

    // ==========================================================
    // Pointer update.
    // A pending load wins over the start loads, which win over counting.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ptr_reg <= sbp_pkg::PTR_RESET;
        end else if (loadPending_reg) begin
            ptr_reg <= loadData_reg;
        end else if (!startOne_n) begin
            ptr_reg <= startOne_reg;
        end else if (!startTwo_n) begin
            ptr_reg <= startTwo_reg;
        end else if (!countEn_n) begin
            ptr_reg <= ptr_next;
        end
    end

    // ==========================================================
    // Flag clear requests from the control register.
    logic flagOneClear;
    logic flagTwoClear;
    assign flagOneClear = ctlWrite && !regDataIn[sbp_pkg::CTL_FLAG_ONE_BIT];
    assign flagTwoClear = ctlWrite && !regDataIn[sbp_pkg::CTL_FLAG_TWO_BIT];

    // ==========================================================
    // End-of-buffer compare one.
    // A flag sets on the increment that lands on its end address.
    sbp_end_compare #(.ADDR_W(ADDR_W)) u_endOne (
        .clk(clk),
        .sys_rst(sys_rst),
        .ptrAdvance(ptrAdvance),
        .ptrNext(ptr_next),
        .endAddr(endOne_reg),
        .flagClear(flagOneClear),
        .endFlag_n(end_flag_one_n)
    );

    // ==========================================================
    // End-of-buffer compare two.
    sbp_end_compare #(.ADDR_W(ADDR_W)) u_endTwo (
        .clk(clk),
        .sys_rst(sys_rst),
        .ptrAdvance(ptrAdvance),
        .ptrNext(ptr_next),
        .endAddr(endTwo_reg),
        .flagClear(flagTwoClear),
        .endFlag_n(end_flag_two_n)
    );

endmodule // sbp_sequential_port

// [include/sbp_pkg.sv]
package sbp_pkg;
    // ==========================================================
    // Geometry.
    localparam int ADDR_W = 13;
    localparam int DATA_W = 16;
    localparam int DEPTH = 8192;
    // ==========================================================
    // Command register map (random-side register port).
    localparam logic [2:0] REG_START_ONE = 3'h0;
    localparam logic [2:0] REG_START_TWO = 3'h1;
    localparam logic [2:0] REG_END_ONE = 3'h2;
    localparam logic [2:0] REG_END_TWO = 3'h3;
    localparam logic [2:0] REG_FLAGS = 3'h4;
    localparam logic [2:0] REG_BUFFER_CONTROL = 3'h5;
    // ==========================================================
    // Control field positions and reset values.
    localparam int CTL_FLAG_ONE_BIT = 0;
    localparam int CTL_FLAG_TWO_BIT = 1;
    localparam logic [15:0] CTL_RESET = 16'h0003;
    localparam logic [12:0] PTR_RESET = 13'h0000;
endpackage

// [hdl/sbp_end_compare.sv]
`timescale 1ns/1ps
module sbp_end_compare #(
    parameter int ADDR_W = 13
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ptrAdvance,
    input wire logic [ADDR_W-1:0] ptrNext,
    input wire logic [ADDR_W-1:0] endAddr,
    input wire logic flagClear,
    output logic endFlag_n
);
    // ==========================================================
    // Flag goes low when an increment lands on the end address.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            endFlag_n <= 1'b1;
        end else if (ptrAdvance && ptrNext == endAddr) begin
            endFlag_n <= 1'b0;
        end else if (flagClear) begin
            endFlag_n <= 1'b1;
        end
    end
endmodule // sbp_end_compare

// [verif/sbp_port_monitor.sv]
`timescale 1ns/1ps
// ==========================================================
// Port checker.
module sbp_port_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic seq_port_enable_n,
    input wire logic pointer_count_en_n,
    input wire logic seq_read_write,
    input wire logic seq_output_enable_n,
    input wire logic regSelect_n,
    input wire logic seqDataOe_n,
    input wire logic end_flag_one_n,
    input wire logic end_flag_two_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_oe_async: assert property (seq_output_enable_n |-> seqDataOe_n) else $error("oe");
    chk_port_off: assert property (seq_port_enable_n [*4] |-> seqDataOe_n) else $error("off");
    chk_write_hiz: assert property (!seq_read_write [*4] |-> seqDataOe_n) else $error("wr");
    chk_read_drive: assert property (
        (!seq_port_enable_n && seq_read_write && !seq_output_enable_n) [*4] |-> !seqDataOe_n) else $error("rd");
    chk_one_hold: assert property (
        !end_flag_one_n && $past(regSelect_n) && $past(regSelect_n, 2) |=> !end_flag_one_n) else $error("h1");
    chk_two_hold: assert property (
        !end_flag_two_n && $past(regSelect_n) && $past(regSelect_n, 2) |=> !end_flag_two_n) else $error("h2");
    chk_clear_cause: assert property (
        $rose(end_flag_one_n) |-> !$past(regSelect_n, 2) || !$past(regSelect_n, 3)) else $error("clr");
    chk_flag_cause: assert property (
        $fell(end_flag_one_n) |-> !$past(pointer_count_en_n, 2) || !$past(pointer_count_en_n, 3)) else $error("set");
    chk_reset_flags: assert property (
        $fell(sys_rst) |-> end_flag_one_n && end_flag_two_n) else $error("rst");
endmodule // sbp_port_monitor

bind sbp_sequential_port sbp_port_monitor mon (.clk, .sys_rst, .seq_port_enable_n, .pointer_count_en_n,
    .seq_read_write, .seq_output_enable_n, .regSelect_n, .seqDataOe_n, .end_flag_one_n, .end_flag_two_n);

// [verif/sbp_bus_master_model.sv]
`timescale 1ns/1ps
// ==========================================================
// Master side of the sequential data bus.
module sbp_bus_master_model (
    input wire logic clk,
    input wire logic mDrive,
    input wire logic [15:0] mData,
    input wire logic [15:0] seqDataOut,
    input wire logic seqDataOe_n,
    output logic [15:0] seqDataIn
);
    logic [15:0] lastReg = 16'h0000;
    always @(posedge clk) begin
        lastReg <= seqDataIn;
    end
    always_comb begin
        if (mDrive) seqDataIn = mData;
        else if (!seqDataOe_n) seqDataIn = seqDataOut;
        else seqDataIn = ~lastReg;
    end
endmodule // sbp_bus_master_model

// [verif/test_sbp_sequential_port.sv]
`timescale 1ns/1ps
`define SBP_CHK(a, e, m) begin nCompared++; if ((a) !== (e)) begin nErrors++; $display("MISMATCH %0t %s", $time, m); end end
// ==========================================================
// Bench.
module test_sbp_sequential_port;
    logic clk, sys_rst, seqDataOe_n, seq_port_enable_n, pointer_count_en_n, seq_read_write, pointer_load_n;
    logic start_load_one_n, start_load_two_n, seq_output_enable_n, end_flag_one_n, end_flag_two_n;
    logic regSelect_n, regWrite, randEnable_n, randWrite, mDrive;
    logic [15:0] seqDataIn, seqDataOut, randDataIn, randDataOut, mData;
    logic [2:0] regAddr;
    logic [12:0] regDataIn, regDataOut, randAddr;
    int nErrors = 0, nCompared = 0, cycles = 0;
    sbp_sequential_port uut (.*);
    sbp_bus_master_model master (.clk, .mDrive, .mData, .seqDataOut, .seqDataOe_n, .seqDataIn);
    always #25 clk = ~clk;
    task automatic conclude();
        $display("compared %0d mismatches %0d", nCompared, nErrors);
        if (nErrors == 0 && nCompared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            nErrors++;
            conclude();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic reg_wr(input logic [2:0] a, input logic [12:0] d);
        regAddr = a;
        regDataIn = d;
        regWrite = 1;
        regSelect_n = 0;
        cyc(3);
        regSelect_n = 1;
        regWrite = 0;
        cyc(3);
    endtask
    task automatic reg_rd(input logic [2:0] a, input logic [12:0] e);
        regAddr = a;
        regSelect_n = 0;
        cyc(3);
        `SBP_CHK(regDataOut, e, "register read")
        regSelect_n = 1;
        cyc(1);
    endtask
    task automatic rand_acc(input logic w, input logic [12:0] a, input logic [15:0] d);
        randWrite = w;
        randAddr = a;
        randDataIn = d;
        randEnable_n = 0;
        cyc(4);
        if (!w) `SBP_CHK(randDataOut, d, "array read")
        randEnable_n = 1;
        cyc(1);
    endtask
    task automatic pins(input logic [5:0] p, input logic [15:0] d);
        {pointer_load_n, start_load_one_n, start_load_two_n, pointer_count_en_n, seq_read_write, seq_port_enable_n} = p;
        mData = d;
        mDrive = !p[1] || !p[5];
        @(negedge clk);
    endtask
    initial begin
        {clk, sys_rst, regWrite, randWrite, mDrive} = 5'h18;
        {seq_output_enable_n, regSelect_n, randEnable_n} = 3'h7;
        {regAddr, regDataIn, randAddr, randDataIn, mData} = '0;
        pins(6'h3F, 16'h0000);
        cyc(1);
        sys_rst = 0;
        `SBP_CHK({end_flag_one_n, end_flag_two_n, seqDataOe_n}, 3'h7, "reset outputs")
        reg_rd(sbp_pkg::REG_START_TWO, 13'h0000);
        reg_rd(sbp_pkg::REG_END_ONE, 13'h1FFF);
        reg_rd(sbp_pkg::REG_BUFFER_CONTROL, 13'h0003);
        reg_rd(3'h6, 13'h0000);
        $display("test reset done");
        reg_wr(sbp_pkg::REG_START_ONE, 13'h0010);
        reg_wr(sbp_pkg::REG_END_ONE, 13'h0012);
        reg_wr(sbp_pkg::REG_START_TWO, 13'h1FFE);
        reg_wr(sbp_pkg::REG_END_TWO, 13'h0000);
        pins(6'h2F, 16'h0000);
        for (int i = 0; i < 3; i++) pins(6'h38, 16'hC001 + i[15:0]);
        pins(6'h3F, 16'h0000);
        cyc(3);
        `SBP_CHK({end_flag_one_n, end_flag_two_n}, 2'h1, "first end")
        for (int i = 0; i < 3; i++) rand_acc(0, 13'h0010 + i[12:0], 16'hC001 + i[15:0]);
        reg_wr(sbp_pkg::REG_BUFFER_CONTROL, 13'h0002);
        `SBP_CHK({end_flag_one_n, end_flag_two_n}, 2'h3, "flag clear")
        reg_wr(sbp_pkg::REG_BUFFER_CONTROL, 13'h0003);
        $display("test write burst done");
        pins(6'h1F, 16'hE011);
        pins(6'h3F, 16'h0000);
        seq_output_enable_n = 0;
        repeat (5) pins(6'h3E, 16'h0000);
        `SBP_CHK({seqDataOe_n, seqDataOut}, 17'h0C002, "loaded read")
        seq_output_enable_n = 1;
        #1 `SBP_CHK(seqDataOe_n, 1'b1, "output off")
        pins(6'h3F, 16'h0000);
        $display("test pointer load done");
        rand_acc(1, 13'h1FFF, 16'hA5A5);
        randWrite = 0;
        randEnable_n = 0;
        pins(6'h37, 16'h0000);
        repeat (2) pins(6'h39, 16'h5A5A);
        pins(6'h3F, 16'h0000);
        cyc(3);
        randEnable_n = 1;
        `SBP_CHK({end_flag_one_n, end_flag_two_n}, 2'h2, "wrap end")
        rand_acc(0, 13'h1FFF, 16'hA5A5);
        $display("test wrap done");
        conclude();
    end
endmodule // test_sbp_sequential_port
